// file: logic/brg_consts.svh
// Function
// - divider reloads at two and toggles output, giving source divided by divisor
// - both dividers may be chained; chained is the reset default
// - odd divisor counts by three on the first step of each high half, then by two
// - divisors 1 to 65535; 3 gives 33 percent, 1 passes source through
// - timer counts system clocks (b counts a's output when chained) down to one and flags expiry
// - start command begins or restarts the count from the loaded value
// - clearing gate pauses the timer; optional terminal pulse on timer output pin
// - each serial machine picks 1X or 16X; 1X uses only the serial clock pin
// - config write resets the divider; mode changes only after reset
// - local loopback feeds transmit into receive, transmit pin held at mark
// - local loopback shorts modem outputs to inputs, all four modem pins held at zero
// - remote loopback ties receive pin to transmit pin, receiver sees mark
// - echo pushes each read character and flags back onto transmit queue
// - echo may suppress control characters and characters with errors
// - power-down command with crystal source enters sleep, clock stopped
// - sleep exits by hardware reset, or level read then software reset
// - power-down with running clock enters idle, contents kept
// - a level register read leaves idle; that read returns invalid data
`ifndef BRG_CONSTS_SVH
`define BRG_CONSTS_SVH
`define A_DIV_LO 4'h0
`define A_DIV_HI 4'h1
`define A_B_LO 4'h2
`define A_B_HI 4'h3
`define A_CFG_A 4'h4
`define A_CFG_B 4'h5
`define A_CMD 4'h6
`define A_STAT 4'h7
`define A_DIAG 4'h8
`define A_FLR 4'h9
`define A_MODEM 4'ha
`define DIV_A_RST 16'h0002
`define DIV_B_RST 16'h0000
`define CFG_RST 8'h01
`define CMD_START_A 0
`define CMD_START_B 1
`define CMD_PDOWN 2
`define CMD_SWRST 3
`define CFG_CHAIN 0
`define CFG_TIMER 1
`define CFG_PULSE 2
`define CFG_GATE 3
`define CFG_TX1X 4
`define CFG_RX1X 5
`endif

// file: logic/brg_pkg.sv
package brg_pkg;
	typedef enum logic [2:0] {
		PW_RUN = 3'b001,
		PW_IDLE = 3'b010,
		PW_SLEEP = 3'b100
	} pwr_t;
	typedef struct packed {
		logic [15:0] divisor;
		logic timer_mode;
		logic pulse_en;
		logic gate;
	} div_cfg_t;
	typedef struct packed {
		logic tick;
		logic clk_out;
		logic expired;
	} div_out_t;
endpackage

// file: logic/rate_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "brg_consts.svh"
module rate_divider
	import brg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic sync_rst,
	input wire logic src_en,
	input wire logic start,
	input var div_cfg_t cfg,
	output var div_out_t dout
);
	logic [15:0] cnt, next_cnt;
	logic clk_o, next_clk_o, first, next_first, running, next_running;
	logic expired, next_expired;

	always_comb begin
		next_cnt = cnt;
		next_clk_o = clk_o;
		next_first = first;
		next_running = running;
		next_expired = 1'b0;
		if (sync_rst) begin
			next_cnt = cfg.divisor;
			next_clk_o = 1'b0;
			next_first = 1'b0;
			next_running = 1'b0;
		end else if (cfg.timer_mode) begin
			if (start) begin
				next_cnt = cfg.divisor;
				next_running = 1'b1;
			end else if (running && cfg.gate && src_en) begin
				if (cnt <= 16'h0001) begin
					next_expired = 1'b1;
					next_running = 1'b0;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
		end else if (src_en) begin
			if (cfg.divisor == 16'h0001) begin
				next_clk_o = ~clk_o;
			end else if (first && cfg.divisor[0]) begin
				// odd divisor: the high half starts one lower, so the period stays at divisor
				next_first = 1'b0;
				if (cnt - 16'h0001 <= 16'h0002) begin
					next_cnt = cfg.divisor;
					next_clk_o = ~clk_o;
				end else begin
					next_cnt = cnt - 16'h0003;
				end
			end else if (cnt <= 16'h0002) begin
				next_first = ~clk_o;
				next_cnt = cfg.divisor;
				next_clk_o = ~clk_o;
			end else begin
				next_cnt = cnt - 16'h0002;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 16'h0000;
			clk_o <= 1'b0;
			first <= 1'b0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			cnt <= next_cnt;
			clk_o <= next_clk_o;
			first <= next_first;
			running <= next_running;
			expired <= next_expired;
		end
	end

	assign dout.clk_out = clk_o;
	assign dout.tick = src_en && !cfg.timer_mode && (next_clk_o != clk_o);
	assign dout.expired = expired;

	chk_timer_restart: assert property (@(posedge clk) disable iff (!resetn)
		(start && cfg.timer_mode && !sync_rst) |=> (running && cnt == $past(cfg.divisor)))
		else $error("timer did not restart from loaded value");
endmodule
`default_nettype wire

// file: logic/brg_diag_power.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "brg_consts.svh"
module brg_diag_power
	import brg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic xtal_src,
	input wire logic sclk_pin,
	input wire logic rxd_pin,
	output logic txd_pin,
	input wire logic tx_serial,
	output logic rx_serial,
	output logic tx_clk_en,
	output logic rx_clk_en,
	input wire logic [2:0] modem_in,
	input wire logic [3:0] modem_out,
	output logic [2:0] modem_seen,
	output logic [3:0] modem_pins,
	output logic timer_output_a,
	output logic timer_output_b,
	input wire logic rx_read,
	input wire logic [7:0] rx_char,
	input wire logic [2:0] rx_flags,
	output logic echo_push,
	output logic [10:0] echo_data,
	output logic sys_clk_stop,
	output logic timer_irq
);
	import brg_pkg::*;
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] sclk_s, rxd_s;
	logic [2:0] mi_s1, mi_s2;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_s <= 2'b00;
			rxd_s <= 2'b11;
			mi_s1 <= 3'h0;
			mi_s2 <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[0], sclk_pin};
			rxd_s <= {rxd_s[0], rxd_pin};
			mi_s1 <= modem_in;
			mi_s2 <= mi_s1;
		end
	end
	logic sclk_d;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) sclk_d <= 1'b0;
		else sclk_d <= sclk_s[1];
	end
	wire sclk_rise = sclk_s[1] & ~sclk_d;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] div_a, div_b, next_div_a, next_div_b;
	logic [7:0] cfg_a, cfg_b, next_cfg_a, next_cfg_b, diag, next_diag;
	logic [1:0] stat, next_stat;
	logic [7:0] rdata_n;
	logic rst_a, rst_b, swrst;
	pwr_t pwr, next_pwr;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction

	div_out_t out_a, out_b;
	assign swrst = wr && hit(addr, `A_CMD) && wdata[`CMD_SWRST];
	assign rst_a = swrst || (wr && hit(addr, `A_CFG_A));
	assign rst_b = swrst || (wr && hit(addr, `A_CFG_B));

	always_comb begin
		next_div_a = div_a;
		next_div_b = div_b;
		next_cfg_a = cfg_a;
		next_cfg_b = cfg_b;
		next_diag = diag;
		next_stat = stat;
		next_pwr = pwr;
		if (out_a.expired) next_stat[0] = 1'b1;
		if (out_b.expired) next_stat[1] = 1'b1;
		if (swrst) begin
			next_div_a = `DIV_A_RST;
			next_div_b = `DIV_B_RST;
			next_cfg_a = `CFG_RST;
			next_cfg_b = `CFG_RST;
			next_diag = 8'h00;
			next_stat = 2'b00;
			next_pwr = PW_RUN;
		end else if (wr) begin
			unique case (addr)
				`A_DIV_LO: next_div_a[7:0] = wdata;
				`A_DIV_HI: next_div_a[15:8] = wdata;
				`A_B_LO: next_div_b[7:0] = wdata;
				`A_B_HI: next_div_b[15:8] = wdata;
				`A_CFG_A: next_cfg_a = wdata;
				`A_CFG_B: next_cfg_b = wdata;
				`A_DIAG: next_diag = wdata;
				`A_STAT: next_stat = stat & ~wdata[1:0] | {out_b.expired, out_a.expired};
				`A_CMD: begin
					if (wdata[`CMD_PDOWN] && pwr == PW_RUN)
						next_pwr = xtal_src ? PW_SLEEP : PW_IDLE;
				end
				default: ;
			endcase
		end
		if (rd && hit(addr, `A_FLR) && pwr == PW_IDLE) next_pwr = PW_RUN;
	end

	always_comb begin
		rdata_n = 8'h00;
		if (rd) begin
			unique case (addr)
				`A_DIV_LO: rdata_n = div_a[7:0];
				`A_DIV_HI: rdata_n = div_a[15:8];
				`A_B_LO: rdata_n = div_b[7:0];
				`A_B_HI: rdata_n = div_b[15:8];
				`A_CFG_A: rdata_n = cfg_a;
				`A_CFG_B: rdata_n = cfg_b;
				`A_STAT: rdata_n = {5'h00, pwr == PW_IDLE, stat};
				`A_DIAG: rdata_n = diag;
				`A_FLR: rdata_n = 8'h00; // level lives in the fifo block; exit read is invalid
				default: rdata_n = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_a <= `DIV_A_RST;
			div_b <= `DIV_B_RST;
			cfg_a <= `CFG_RST;
			cfg_b <= `CFG_RST;
			diag <= 8'h00;
			stat <= 2'b00;
			pwr <= PW_RUN;
			rdata <= 8'h00;
		end else begin
			div_a <= next_div_a;
			div_b <= next_div_b;
			cfg_a <= next_cfg_a;
			cfg_b <= next_cfg_b;
			diag <= next_diag;
			stat <= next_stat;
			pwr <= next_pwr;
			rdata <= rdata_n;
		end
	end

	// ----------------------------------------
	// dividers; chained b follows a's output
	// ----------------------------------------
	wire run_en = (pwr == PW_RUN);
	wire chain = cfg_a[`CFG_CHAIN];
	div_cfg_t ca, cb;
	assign ca = '{divisor: div_a, timer_mode: cfg_a[`CFG_TIMER],
		pulse_en: cfg_a[`CFG_PULSE], gate: cfg_a[`CFG_GATE]};
	assign cb = '{divisor: div_b, timer_mode: cfg_b[`CFG_TIMER],
		pulse_en: cfg_b[`CFG_PULSE], gate: cfg_b[`CFG_GATE]};
	wire start_a = wr && hit(addr, `A_CMD) && wdata[`CMD_START_A];
	wire start_b = wr && hit(addr, `A_CMD) && wdata[`CMD_START_B];

	rate_divider u_a (
		.clk(clk), .resetn(resetn), .sync_rst(rst_a), .src_en(run_en),
		.start(start_a), .cfg(ca), .dout(out_a)
	);
	rate_divider u_b (
		.clk(clk), .resetn(resetn), .sync_rst(rst_b),
		.src_en(run_en && (chain ? out_a.tick && out_a.clk_out == 1'b0 : 1'b1)),
		.start(start_b), .cfg(cb), .dout(out_b)
	);

	// ----------------------------------------
	// outputs: clocking, diagnostics, echo, power
	// ----------------------------------------
	logic local_lb, remote_lb, echo_on, sup_ctl, sup_err;
	assign local_lb = diag[0];
	assign remote_lb = diag[1];
	assign echo_on = diag[2];
	assign sup_ctl = diag[3];
	assign sup_err = diag[4];
	wire is_ctl = (rx_char[7:5] == 3'h0) || (rx_char == 8'h7f);
	wire b_clk = chain ? out_b.tick : out_a.tick;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txd_pin <= 1'b1;
			rx_serial <= 1'b1;
			tx_clk_en <= 1'b0;
			rx_clk_en <= 1'b0;
			modem_seen <= 3'h0;
			modem_pins <= 4'h0;
			timer_output_a <= 1'b0;
			timer_output_b <= 1'b0;
			echo_push <= 1'b0;
			echo_data <= 11'h000;
			sys_clk_stop <= 1'b0;
			timer_irq <= 1'b0;
		end else begin
			tx_clk_en <= cfg_a[`CFG_TX1X] ? sclk_rise : b_clk;
			rx_clk_en <= cfg_a[`CFG_RX1X] ? sclk_rise : (chain ? out_b.tick : out_b.tick | out_a.tick);
			txd_pin <= local_lb ? 1'b1 : (remote_lb ? rxd_s[1] : tx_serial);
			rx_serial <= local_lb ? tx_serial : (remote_lb ? 1'b1 : rxd_s[1]);
			modem_seen <= local_lb ? modem_out[3:1] : mi_s2;
			modem_pins <= local_lb ? 4'h0 : modem_out;
			timer_output_a <= cfg_a[`CFG_TIMER] ? (out_a.expired & cfg_a[`CFG_PULSE]) : out_a.clk_out;
			timer_output_b <= cfg_b[`CFG_TIMER] ? (out_b.expired & cfg_b[`CFG_PULSE]) : out_b.clk_out;
			echo_push <= echo_on && rx_read && !(sup_ctl && is_ctl) && !(sup_err && |rx_flags);
			echo_data <= {rx_flags, rx_char};
			sys_clk_stop <= (next_pwr == PW_SLEEP);
			timer_irq <= |next_stat;
		end
	end

	chk_echo_suppress: assert property (@(posedge clk) disable iff (!resetn)
		(rx_read && echo_on && sup_err && |rx_flags) |=> !echo_push)
		else $error("errored character echoed");
	chk_local_mark: assert property (@(posedge clk) disable iff (!resetn)
		(local_lb && !swrst) |=> txd_pin)
		else $error("transmit pin not at mark in local loopback");
	chk_remote_path: assert property (@(posedge clk) disable iff (!resetn)
		(remote_lb && !local_lb) |=> rx_serial)
		else $error("receive machine not isolated in remote loopback");
	chk_idle_exit: assert property (@(posedge clk) disable iff (!resetn)
		(pwr == PW_IDLE && rd && addr == `A_FLR) |=> pwr == PW_RUN)
		else $error("level read did not leave idle");
	chk_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
		(wr && addr == `A_CMD && wdata == 8'h04 && pwr == PW_RUN && xtal_src) |=> ##1 sys_clk_stop)
		else $error("sleep not entered");
	cov_echo: cover property (@(posedge clk) echo_push);
	cov_idle: cover property (@(posedge clk) pwr == PW_IDLE);
	cov_expire: cover property (@(posedge clk) out_a.expired);
endmodule
`default_nettype wire

// file: tb/baud_timer_diag_power_test.sv
`timescale 1ns/1ps
`default_nettype none
module baud_timer_diag_power_test;
import brg_pkg::*;
logic clk, resetn, wr, rd, xtal_src, sclk_pin, rxd_pin, tx_serial, rx_read;
logic [3:0] addr, modem_out;
logic [7:0] wdata, rx_char, rdata;
logic [2:0] modem_in, rx_flags, modem_seen;
logic txd_pin, rx_serial, tx_clk_en, rx_clk_en, ta, tb, echo_push, sys_clk_stop, timer_irq;
logic [3:0] modem_pins;
logic [10:0] echo_data;
logic hit[2];
logic pul;
int failures, check_count, cycles, t0, t1;
brg_diag_power brg_diag_power_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .xtal_src(xtal_src), .sclk_pin(sclk_pin),
	.rxd_pin(rxd_pin), .txd_pin(txd_pin), .tx_serial(tx_serial), .rx_serial(rx_serial),
	.tx_clk_en(tx_clk_en), .rx_clk_en(rx_clk_en), .modem_in(modem_in),
	.modem_out(modem_out), .modem_seen(modem_seen), .modem_pins(modem_pins),
	.timer_output_a(ta), .timer_output_b(tb), .rx_read(rx_read), .rx_char(rx_char),
	.rx_flags(rx_flags), .echo_push(echo_push), .echo_data(echo_data),
	.sys_clk_stop(sys_clk_stop), .timer_irq(timer_irq));
// ----------------------------------------
// clock, timeout and shared tasks
// ----------------------------------------
initial begin
	clk = 0;
	forever #2.5 clk = ~clk;
end
// whole run is about fifteen hundred cycles, so this ceiling only trips on a hang
always @(posedge clk) begin
	cycles++;
	if (cycles == 20000) begin
		failures++;
		results();
	end
end
task results();
	$display("checks %0d failures %0d", check_count, failures);
	if (failures == 0 && check_count > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
task check(input logic [15:0] seen, input logic [15:0] exp);
	check_count++;
	if (seen !== exp) begin
		failures++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task wr_reg(input logic [3:0] a, input logic [7:0] d);
	@(posedge clk);
	addr <= a;
	wdata <= d;
	wr <= 1;
	@(posedge clk);
	wr <= 0;
endtask
task rd_chk(input logic [3:0] a, input logic [7:0] exp);
	@(posedge clk);
	addr <= a;
	rd <= 1;
	@(posedge clk);
	rd <= 0;
	#1 check(rdata, exp);
endtask
task hw_reset();
	resetn <= 0;
	repeat (20) @(posedge clk);
	resetn <= 1;
endtask
task wait_chk(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
// rising edges of output a, spaced by the divisor when sourced from the system clock
task period(output int p);
	int c;
	logic pv;
	c = 0;
	t0 = 0;
	pv = 1;
	while (c < 300) begin
		@(posedge clk);
		#1 c++;
		if (ta === 1 && pv === 0) begin
			if (t0 == 0) t0 = c;
			else if (t1 == 0) t1 = c;
		end
		pv = ta;
	end
	p = t1 - t0;
endtask
task run_timer(input logic [7:0] cfg, output logic irq, output logic pulse);
	wr_reg(4'h4, cfg);
	wr_reg(4'h0, 8'h05);
	wr_reg(4'h1, 8'h00);
	wr_reg(4'h7, 8'h03);
	wait_chk(10);
	check(timer_irq, 0);
	wr_reg(4'h6, 8'h01);
	irq = 0;
	pulse = 0;
	repeat (30) begin
		@(posedge clk);
		#1 irq = irq | (timer_irq === 1);
		pulse = pulse | (ta === 1);
	end
endtask
task echo(input logic [7:0] c, input logic [2:0] f, input logic exp);
	logic seen;
	logic [10:0] d;
	seen = 0;
	@(posedge clk);
	rx_char <= c;
	rx_flags <= f;
	rx_read <= 1;
	@(posedge clk);
	rx_read <= 0;
	repeat (10) begin
		#1 if (echo_push === 1) begin
			seen = 1;
			d = echo_data;
		end
		@(posedge clk);
	end
	check(seen, exp);
	if (exp) check(d, {f, c});
endtask
// ----------------------------------------
// test sequence
// ----------------------------------------
initial begin
	int p;
	resetn = 0; wr = 0; rd = 0; addr = 0; wdata = 0; xtal_src = 0; sclk_pin = 0;
	rxd_pin = 1; tx_serial = 1; rx_read = 0; rx_char = 0; rx_flags = 0;
	modem_in = 3'b010; modem_out = 4'h0; failures = 0; check_count = 0; cycles = 0;
	hw_reset();
	check(txd_pin, 1);
	rd_chk(4'h0, 8'h02);
	rd_chk(4'h1, 8'h00);
	rd_chk(4'h2, 8'h00);
	rd_chk(4'h4, 8'h01);
	rd_chk(4'hb, 8'h00);
	$display("test reset done");
	wr_reg(4'h4, 8'h00);
	for (int d = 2; d <= 5; d++) begin
		wr_reg(4'h0, d[7:0]);
		wr_reg(4'h1, 8'h00);
		t1 = 0;
		period(p);
		check(p[15:0], d[15:0]);
	end
	$display("test divider done");
	run_timer(8'h06, hit[0], pul);
	run_timer(8'h0e, hit[1], pul);
	check(hit[0] != hit[1], 1);
	run_timer(hit[1] ? 8'h0e : 8'h06, hit[0], pul);
	check(hit[0], 1);
	check(pul, 1);
	rd_chk(4'h7, 8'h01);
	wr_reg(4'h7, 8'h01);
	wait_chk(2);
	check(timer_irq, 0);
	$display("test timer done");
	wr_reg(4'h8, 8'h01);
	tx_serial <= 0;
	modem_out <= 4'b1010;
	wait_chk(5);
	check(rx_serial, 0);
	check(txd_pin, 1);
	check(modem_seen, 3'b101);
	check(modem_pins, 4'h0);
	wr_reg(4'h8, 8'h02);
	rxd_pin <= 0;
	wait_chk(6);
	check(txd_pin, 0);
	check(rx_serial, 1);
	$display("test loopback done");
	wr_reg(4'h8, 8'h0c);
	echo(8'h41, 3'b000, 1);
	echo(8'h05, 3'b000, 0);
	echo(8'h7f, 3'b000, 0);
	wr_reg(4'h8, 8'h04);
	echo(8'h05, 3'b001, 1);
	$display("test echo done");
	wr_reg(4'h6, 8'h04);
	rd_chk(4'h7, 8'h04);
	check(sys_clk_stop, 0);
	rd_chk(4'h0, 8'h05);
	@(posedge clk);
	rd <= 1;
	addr <= 4'h9;
	@(posedge clk);
	rd <= 0;
	rd_chk(4'h7, 8'h00);
	xtal_src <= 1;
	wr_reg(4'h6, 8'h04);
	wait_chk(3);
	check(sys_clk_stop, 1);
	hw_reset();
	wait_chk(1);
	check(sys_clk_stop, 0);
	rd_chk(4'h0, 8'h02);
	$display("test power done");
	results();
end
endmodule
`default_nettype wire
